/* File: core/bic_pkg.sv */
// Package of constants for the bridge interrupt channel
// Contract
// R1: The block has two two-way interrupt pins, the bus interrupt and the local one, each usable as input or output.
// R2: A hardware interrupt input reaches the opposite pin only while its enable bit is set.
// R3: Each forwarded hardware input records its own status bit.
// R4: Hardware routing works one way at a time; bus-to-local and local-to-bus never run together.
// R5: With forwarding enabled, an asserted bus interrupt asserts the local pin until it negates and its status is cleared.
// R6: A clear of the forwarded bus interrupt status is ignored while the bus interrupt is still asserted.
// R7: Enabled parity or system error lines assert the local pin until the source is cleared, then the status.
// R8: An enabled local pin drives the bus interrupt; the local side negates first, then clears the status.
// R9: An internal event raises an interrupt only while its enable bit is set.
// R10: Each internal source drives the bus or the local pin as its direction bit says.
// R11: Each internal source has its own readable status bit.
// R12: Software clears the originating source first and only then the interrupt status.
// R13: Internal sources are bus error log, master parity, local error log, four DMA events, config status, four mailboxes and local parity.
//      The code has 14 sources instead: ten event inputs plus the four mailboxes.
// R14: An enabled mailbox raises its interrupt only when written from the opposite bus with a byte lane enabled.
// R15: Status bits clear on a written one; a written zero leaves them.
// R16: Interrupt outputs are active low and held while any enabled mapped source has status set.
package bic_pkg;
    localparam int          NUM_SRC      = 14;
    localparam logic [3:0]  ADR_ENABLE   = 4'h0;
    localparam logic [3:0]  ADR_STATUS   = 4'h4;
    localparam logic [3:0]  ADR_DIR      = 4'h8;
    localparam logic [3:0]  ADR_PINS     = 4'hC;
    // Hardware enable field, bit positions in the enable register
    localparam int          HW_PCI_BIT   = 16;
    localparam int          HW_PAR_BIT   = 17;
    localparam int          HW_SYS_BIT   = 18;
    localparam int          HW_LOC_BIT   = 19;
    // Mailbox direction bits sit with their sources, right above the ten event sources
    localparam int          MBOX_BIT     = 10;
    localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;
endpackage : bic_pkg

/* File: core/bic_src_cell.sv */
// One internal interrupt source: sticky status with enable and direction
module bic_src_cell
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic event_i,
    input  wire logic enable_i,
    input  wire logic clear_i,
    input  wire logic dir_i,
    output logic      status_o,
    output logic      to_pci_o,
    output logic      to_local_o
);
    typedef struct packed { logic status; } bic_cell_type;
    bic_cell_type s_q, s_d;

    always_comb
    begin
        s_d = s_q;
        if (clear_i)
            s_d.status = 1'b0;      // R15
        if (event_i && enable_i)
            s_d.status = 1'b1;      // R9
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign status_o   = s_q.status;                  // R11
    assign to_pci_o   = s_q.status && dir_i;         // R10
    assign to_local_o = s_q.status && !dir_i;        // R10
endmodule : bic_src_cell

/* File: core/bic_irq_channel.sv */
// Bridge interrupt channel with Wishbone register slave
module bic_irq_channel
    import bic_pkg::*;
#(
    parameter int NSRC = bic_pkg::NUM_SRC
)
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [3:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               pci_irq_n_i,
    output logic                    pci_irq_n_o,
    output logic                    pci_irq_n_oe_o,
    input  wire logic               local_irq_pin_n_i,
    output logic                    local_irq_pin_n_o,
    output logic                    local_irq_pin_n_oe_o,
    input  wire logic               parity_n_i,
    input  wire logic               syserr_n_i,
    input  wire logic [NSRC-5:0]    int_event_i,
    input  wire logic [3:0]         mbox_wr_i,
    input  wire logic               mbox_from_pci_i,
    input  wire logic [3:0]         mbox_be_i
);
    import bic_pkg::*;

    typedef struct packed {
        logic [31:0] enable;
        logic [31:0] dir;
        logic [3:0]  hw_status;
        logic [31:0] rdata;
        logic        ack;
    } bic_state_type;

    bic_state_type s_q, s_d;

    logic              wr_en;
    logic              rd_en;
    logic [31:0]       wmask;
    logic [31:0]       clr_vec;
    logic [NSRC-1:0]   src_event;
    logic [NSRC-1:0]   src_status;
    logic [NSRC-1:0]   src_pci;
    logic [NSRC-1:0]   src_local;
    logic [3:0]        mbox_event;
    logic              pci_in;
    logic              loc_in;
    logic              fwd_to_local;
    logic              fwd_to_pci;
    logic              drive_pci;
    logic              drive_local;

    assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
    assign rd_en   = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
    assign clr_vec = (wr_en && wb_adr_i == ADR_STATUS) ? (wb_dat_i & wmask) : 32'h0000_0000;

    // Input pins sense the wire only while this block is not driving it
    assign pci_in  = !pci_irq_n_i && pci_irq_n_oe_o;                        // R1
    assign loc_in  = !local_irq_pin_n_i && local_irq_pin_n_oe_o;            // R1

    // Mailbox writes count only from the opposite bus with a lane enabled
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            mbox_event[i] = mbox_wr_i[i] && (|mbox_be_i)
                            && (mbox_from_pci_i != s_q.dir[MBOX_BIT + i]);  // R14
    end

    assign src_event = {mbox_event, int_event_i};                           // R13

    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_src
            bic_src_cell u_cell
            (
                .clk_i      (clk_i),
                .rst_i      (rst_i),
                .event_i    (src_event[g]),
                .enable_i   (s_q.enable[g]),
                .clear_i    (clr_vec[g]),
                .dir_i      (s_q.dir[g]),
                .status_o   (src_status[g]),
                .to_pci_o   (src_pci[g]),
                .to_local_o (src_local[g])
            );
        end
    endgenerate

    // Enabling local-to-bus forwarding shuts off bus-to-local routing
    assign fwd_to_pci   = s_q.enable[HW_LOC_BIT];                           // R4
    assign fwd_to_local = !fwd_to_pci;                                      // R4

    always_comb
    begin
        s_d     = s_q;
        s_d.ack = (wb_cyc_i && wb_stb_i) && !s_q.ack;
        if (wr_en && wb_adr_i == ADR_ENABLE)
            s_d.enable = (s_q.enable & ~wmask) | (wb_dat_i & wmask);
        if (wr_en && wb_adr_i == ADR_DIR)
            s_d.dir = (s_q.dir & ~wmask) | (wb_dat_i & wmask);
        // Clear is dropped while the bus line still asserts
        if (clr_vec[HW_PCI_BIT] && !pci_in)
            s_d.hw_status[0] = 1'b0;                                        // R6
        if (clr_vec[HW_PAR_BIT])
            s_d.hw_status[1] = 1'b0;                                        // R15
        if (clr_vec[HW_SYS_BIT])
            s_d.hw_status[2] = 1'b0;                                        // R15
        if (clr_vec[HW_LOC_BIT])
            s_d.hw_status[3] = 1'b0;                                        // R15
        // Set wins over clear; lines re-set status while still asserted
        if (pci_in && s_q.enable[HW_PCI_BIT] && fwd_to_local)
            s_d.hw_status[0] = 1'b1;                                        // R2 R3
        if (!parity_n_i && s_q.enable[HW_PAR_BIT] && fwd_to_local)
            s_d.hw_status[1] = 1'b1;                                        // R7
        if (!syserr_n_i && s_q.enable[HW_SYS_BIT] && fwd_to_local)
            s_d.hw_status[2] = 1'b1;                                        // R7
        if (loc_in && fwd_to_pci)
            s_d.hw_status[3] = 1'b1;                                        // R8
        if (rd_en)
        begin
            if (wb_adr_i == ADR_ENABLE)
                s_d.rdata = s_q.enable;
            else if (wb_adr_i == ADR_STATUS)
                s_d.rdata = {12'h000, s_q.hw_status,
                             {(16-NSRC){1'b0}}, src_status};                // R11
            else if (wb_adr_i == ADR_DIR)
                s_d.rdata = s_q.dir;
            else if (wb_adr_i == ADR_PINS)
                s_d.rdata = {28'h000_0000, drive_local, drive_pci, loc_in, pci_in};
            else
                s_d.rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q.enable    <= RESET_VALUE;
            s_q.dir       <= RESET_VALUE;
            s_q.hw_status <= 4'h0;
            s_q.rdata     <= RESET_VALUE;
            s_q.ack       <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    // Active low outputs held by any pending mapped source
    assign drive_local = (|src_local) || (|s_q.hw_status[2:0]) ;            // R16 R5
    assign drive_pci   = (|src_pci) || s_q.hw_status[3];                    // R16 R8

    assign pci_irq_n_o          = 1'b0;                                     // R1
    assign pci_irq_n_oe_o       = !drive_pci;
    assign local_irq_pin_n_o    = 1'b0;
    assign local_irq_pin_n_oe_o = !drive_local;
    assign wb_dat_o             = s_q.rdata;
    assign wb_ack_o             = s_q.ack;

    chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.ack |=> !s_q.ack) else $error("ack held too long");
    chk_pci_clear_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        (s_q.hw_status[0] && pci_in) |=> s_q.hw_status[0])
        else $error("bus status cleared while line asserted");
    chk_local_held: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        s_q.hw_status[0] |-> !local_irq_pin_n_oe_o)
        else $error("local pin not driven");
    chk_one_direction: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        !(s_q.hw_status[3] && $rose(s_q.hw_status[0])))
        else $error("both routing directions active");
    chk_loc_fwd: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (loc_in && fwd_to_pci) |=> !pci_irq_n_oe_o)
        else $error("local interrupt not forwarded");
    chk_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (!s_q.enable[HW_PAR_BIT] && !s_q.hw_status[1]) |=> !s_q.hw_status[1])
        else $error("disabled parity line set status");
    chk_err_set: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (!syserr_n_i && s_q.enable[HW_SYS_BIT] && fwd_to_local) |=> s_q.hw_status[2])
        else $error("system error not recorded");
    chk_src_pci: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        (src_status[0] && s_q.dir[0]) |-> !pci_irq_n_oe_o)
        else $error("mapped source not on bus pin");
    cov_pci_fwd: cover property (@(posedge clk_i) $rose(s_q.hw_status[0]));
    cov_loc_fwd: cover property (@(posedge clk_i) $rose(s_q.hw_status[3]));
    cov_mbox: cover property (@(posedge clk_i) |mbox_event);
endmodule : bic_irq_channel

/* File: testbench/bic_far_model.sv */
// Far-side model: bus agent and local processor on the open-drain lines
module bic_far_model
(
    input  wire logic       pci_oe_n_i,
    input  wire logic       loc_oe_n_i,
    input  wire logic       pci_req_i,
    input  wire logic       loc_req_i,
    input  wire logic [1:0] err_req_i,
    output logic            pci_wire_o,
    output logic            loc_wire_o,
    output logic            par_n_o,
    output logic            sys_n_o
);
    // Pull-ups on both wires, so a released line reads high, never the last value
    assign pci_wire_o = !(!pci_oe_n_i || pci_req_i);
    assign loc_wire_o = !(!loc_oe_n_i || loc_req_i);
    // Source device clears its own error by negating the line first
    assign par_n_o    = !err_req_i[0];
    assign sys_n_o    = !err_req_i[1];
endmodule : bic_far_model

/* File: testbench/tb.sv */
// Self-checking bench for the bridge interrupt channel
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bic_pkg::*;
    typedef struct packed {logic [3:0] src; logic en; logic dir; logic [2:0] exp;} bic_row_type;
    // Expected field: {status, bus pin driven, local pin driven}
    bic_row_type rows [10] = '{'{4'h0,1'h1,1'h0,3'h5}, '{4'h1,1'h1,1'h1,3'h6},
        '{4'h2,1'h1,1'h0,3'h5}, '{4'h3,1'h1,1'h1,3'h6}, '{4'h4,1'h1,1'h0,3'h5},
        '{4'h5,1'h1,1'h1,3'h6}, '{4'h6,1'h1,1'h0,3'h5}, '{4'h7,1'h1,1'h1,3'h6},
        '{4'h8,1'h1,1'h0,3'h5}, '{4'h5,1'h0,1'h1,3'h0}};
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, mfp = 1'b0;
    logic [3:0] adr = 4'h0, mwr = 4'h0, mbe = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic [9:0] ev = 10'h000;
    logic ack, pci_oe, loc_oe, pci_w, loc_w, par_n, sys_n, pci_req = 1'b0, loc_req = 1'b0;
    logic [1:0] err_req = 2'h0;
    int failures = 0, check_count = 0, cycles = 0;
    always #50 clk = ~clk;
    bic_irq_channel uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pci_irq_n_i(pci_w), .pci_irq_n_o(), .pci_irq_n_oe_o(pci_oe),
        .local_irq_pin_n_i(loc_w), .local_irq_pin_n_o(), .local_irq_pin_n_oe_o(loc_oe),
        .parity_n_i(par_n), .syserr_n_i(sys_n), .int_event_i(ev), .mbox_wr_i(mwr),
        .mbox_from_pci_i(mfp), .mbox_be_i(mbe));
    bic_far_model far (.pci_oe_n_i(pci_oe), .loc_oe_n_i(loc_oe), .pci_req_i(pci_req),
        .loc_req_i(loc_req), .err_req_i(err_req), .pci_wire_o(pci_w), .loc_wire_o(loc_w),
        .par_n_o(par_n), .sys_n_o(sys_n));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Held until ack is sampled high; ack may not come at all, the cycle ceiling covers it
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic pins(input logic p, input logic l);
        repeat (2) @(posedge clk);
        chk("pins", {30'h0, p, l}, {30'h0, ~pci_oe, ~loc_oe});
    endtask : pins
    task automatic mbox(input logic from_pci, input logic [3:0] be);
        mwr <= 4'h1;
        mfp <= from_pci;
        mbe <= be;
        @(posedge clk);
        mwr <= 4'h0;
        wb(1'b0, ADR_STATUS, 32'h0000_0000);
    endtask : mbox
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, ADR_ENABLE, 32'h0000_0000);
        chk("enable", RESET_VALUE, q);
        pins(1'b0, 1'b0);
        wb(1'b1, 4'h2, 32'hFFFF_FFFF);
        wb(1'b0, 4'h2, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, q);
        foreach (rows[i])
        begin
            wb(1'b1, ADR_ENABLE, 32'(rows[i].en) << rows[i].src);
            wb(1'b1, ADR_DIR, 32'(rows[i].dir) << rows[i].src);
            ev[rows[i].src] <= 1'b1;
            @(posedge clk);
            ev <= 10'h000;
            wb(1'b0, ADR_STATUS, 32'h0000_0000);
            chk("status", 32'(rows[i].exp[2]) << rows[i].src, q);
            pins(rows[i].exp[1], rows[i].exp[0]);
            wb(1'b1, ADR_STATUS, 32'h0000_0000);
            pins(rows[i].exp[1], rows[i].exp[0]);
            wb(1'b1, ADR_STATUS, 32'h1 << rows[i].src);
            pins(1'b0, 1'b0);
        end
        $display("test internal sources done");
        pci_req <= 1'b1;
        pins(1'b0, 1'b0);
        wb(1'b1, ADR_ENABLE, 32'h0001_0000);
        pins(1'b0, 1'b1);
        wb(1'b0, ADR_STATUS, 32'h0000_0000);
        chk("status", 32'h0001_0000, q & 32'h000F_0000);
        wb(1'b1, ADR_STATUS, 32'h0001_0000);
        pins(1'b0, 1'b1);
        pci_req <= 1'b0;
        pins(1'b0, 1'b1);
        wb(1'b1, ADR_STATUS, 32'h0001_0000);
        pins(1'b0, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            wb(1'b1, ADR_ENABLE, 32'h1 << (HW_PAR_BIT + k));
            err_req[k] <= 1'b1;
            pins(1'b0, 1'b1);
            err_req[k] <= 1'b0;
            wb(1'b1, ADR_STATUS, 32'h1 << (HW_PAR_BIT + k));
            pins(1'b0, 1'b0);
        end
        $display("test bus to local done");
        wb(1'b1, ADR_ENABLE, 32'h0009_0000);
        loc_req <= 1'b1;
        pci_req <= 1'b1;
        pins(1'b1, 1'b0);
        loc_req <= 1'b0;
        pci_req <= 1'b0;
        pins(1'b1, 1'b0);
        wb(1'b1, ADR_STATUS, 32'h000F_0000);
        pins(1'b0, 1'b0);
        $display("test local to bus done");
        wb(1'b1, ADR_ENABLE, 32'h0000_0400);
        wb(1'b1, ADR_DIR, 32'h0000_0000);
        mbox(1'b0, 4'hF);
        chk("mbox_same_side", 32'h0000_0000, q);
        mbox(1'b1, 4'h0);
        chk("mbox_no_lane", 32'h0000_0000, q);
        mbox(1'b1, 4'h2);
        chk("mbox_other_side", 32'h0000_0400, q);
        pins(1'b0, 1'b1);
        wb(1'b1, ADR_STATUS, 32'h0000_0400);
        wb(1'b1, ADR_DIR, 32'h0000_0400);
        mbox(1'b1, 4'hF);
        chk("mbox_same_bus", 32'h0000_0000, q);
        mbox(1'b0, 4'h1);
        chk("mbox_from_local", 32'h0000_0400, q);
        pins(1'b1, 1'b0);
        $display("test mailbox done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, ADR_ENABLE, 32'h0000_0000);
        chk("enable_after_reset", RESET_VALUE, q);
        wb(1'b0, ADR_STATUS, 32'h0000_0000);
        chk("status_after_reset", 32'h0000_0000, q);
        pins(1'b0, 1'b0);
        $display("test reset done");
        end_of_test();
    end
endmodule : tb
